// file: rsn_ctrl.sv
`timescale 1ns/100ps
`include "rsn_params.svh"
module rsn_ctrl import rsn_pkg::*; (
  input wire logic clk,
  input wire logic reset,
  input wire logic serial_shift_clock,
  input wire logic select_n,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe,
  input wire logic requant_disable_pin,
  input wire logic [3:0][10:0] adc_data,
  output logic [3:0][10:0] data_out,
  output logic [3:0] requant_on,
  output logic [3:0][2:0] band_mode,
  output logic [3:0][5:0] band_left_step,
  output logic [3:0][6:0] band_width_step,
  output logic self_test_busy
);

  rsn_state_t s_r;
  rsn_state_t s_nxt;

  function automatic logic [7:0] rev8(input logic [7:0] x);
    logic [7:0] y;
    y = 8'h00;
    for (int i = 0; i < 8; i++) begin
      y[i] = x[7-i];
    end
    return y;
  endfunction

  function automatic logic [1:0] first_ch(input logic [3:0] m);
    logic [1:0] c;
    c = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (m[i]) begin
        c = 2'(i);
      end
    end
    return c;
  endfunction

  // Highest legal word per band mode; unknown modes fall back to the 22% limits
  function automatic logic [5:0] tw_max(input logic [2:0] m);
    unique case (m)
      `RSN_MODE33: tw_max = `RSN_TW_CNT33 - 6'h01;
      `RSN_MODE36: tw_max = `RSN_TW_CNT36 - 6'h01;
      default: tw_max = `RSN_TW_CNT22 - 6'h01;
    endcase
  endfunction

  function automatic logic [6:0] bw_step(input logic [2:0] m);
    unique case (m)
      `RSN_MODE33: bw_step = `RSN_BW_STEP33;
      `RSN_MODE36: bw_step = `RSN_BW_STEP36;
      default: bw_step = `RSN_BW_STEP22;
    endcase
  endfunction

  // Shadow copies are read back so software sees what it wrote before a transfer
  function automatic logic [7:0] rd_reg(input rsn_state_t st, input logic [7:0] a,
                                        input logic [1:0] c);
    unique case (a)
      `RSN_A_CFG: rd_reg = st.cfg;
      `RSN_A_CHSEL: rd_reg = {4'h0, st.chsel};
      `RSN_A_TPAT: rd_reg = st.tpat_sh;
      `RSN_A_STCTL: rd_reg = st.st_sh[c];
      `RSN_A_OFMT: rd_reg = st.ofmt_sh;
      `RSN_A_SIG0: rd_reg = st.sig[7:0];
      `RSN_A_SIG1: rd_reg = st.sig[15:8];
      `RSN_A_NSRC: rd_reg = st.nsrc_sh[c];
      `RSN_A_NSRT: rd_reg = st.nsrt_sh[c];
      default: rd_reg = 8'h00;
    endcase
  endfunction

  logic sclk_rise;
  logic sclk_fall;
  logic csn;
  logic csn_rise;
  logic sdi;
  logic lsb;
  logic [1:0] rd_ch;
  logic [15:0] instr;
  logic [7:0] wbyte;
  logic [7:0] naddr;
  logic wr_en;
  logic [3:0] st_mask;
  logic [1:0] sign_ch;
  logic [10:0] pat;
  logic pat_raw;
  logic [10:0] smp;

  always_comb begin
    s_nxt = s_r;
    instr = 16'h0000;
    wbyte = 8'h00;
    naddr = 8'h00;
    wr_en = 1'b0;
    pat = 11'h000;
    pat_raw = 1'b0;
    smp = 11'h000;
    s_nxt.sclk_s = {s_r.sclk_s[1:0], serial_shift_clock};
    s_nxt.csn_s = {s_r.csn_s[1:0], select_n};
    s_nxt.sdi_s = {s_r.sdi_s[0], sdio_in};
    s_nxt.pin_s = {s_r.pin_s[0], requant_disable_pin};
    sclk_rise = s_r.sclk_s[1] & ~s_r.sclk_s[2];
    sclk_fall = ~s_r.sclk_s[1] & s_r.sclk_s[2];
    csn = s_r.csn_s[1];
    csn_rise = csn & ~s_r.csn_s[2];
    sdi = s_r.sdi_s[1];
    lsb = s_r.cfg[`RSN_CFG_LSB];
    rd_ch = (s_r.chsel == 4'h2) ? 2'h1 : (s_r.chsel == 4'h4) ? 2'h2 :
            (s_r.chsel == 4'h8) ? 2'h3 : 2'h0;
    s_nxt.xfer = 1'b0;

    unique case (s_r.sp)
      SP_IDLE: begin
        if (!csn && sclk_rise) begin
          s_nxt.sp = SP_INSTR;
          s_nxt.shift = {15'h0000, sdi};
          s_nxt.bit_cnt = 4'h1;
        end
      end
      SP_INSTR: begin
        if (csn_rise && s_r.bit_cnt[2:0] != 3'h0) begin
          s_nxt.sp = SP_IDLE;
        end else if (!csn && sclk_rise) begin
          s_nxt.shift = {s_r.shift[14:0], sdi};
          s_nxt.bit_cnt = 4'(s_r.bit_cnt + 4'h1);
          if (s_r.bit_cnt == 4'hf) begin
            instr = {s_r.shift[14:0], sdi};
            if (lsb) begin
              instr = {rev8(instr[7:0]), rev8(instr[15:8])};
            end
            s_nxt.rd = instr[15];
            s_nxt.len = instr[14:13];
            s_nxt.addr = instr[7:0];
            s_nxt.sp = SP_DATA;
            s_nxt.bit_cnt = 4'h0;
            s_nxt.byte_cnt = 2'h0;
            s_nxt.obyte = rd_reg(s_r, instr[7:0], rd_ch);
            if (lsb) begin
              s_nxt.obyte = rev8(s_nxt.obyte);
            end
            s_nxt.sdo = s_nxt.obyte[7];
          end
        end
      end
      SP_DATA: begin
        // A rise mid-byte aborts; at a byte boundary it only pauses a counted frame
        if (csn_rise && (s_r.bit_cnt[2:0] != 3'h0 || s_r.len == 2'h3)) begin
          s_nxt.sp = SP_IDLE;
        end else if (!csn && sclk_rise) begin
          s_nxt.shift = {s_r.shift[14:0], sdi};
          s_nxt.bit_cnt = 4'(s_r.bit_cnt + 4'h1);
          if (s_r.bit_cnt[2:0] == 3'h7) begin
            wbyte = {s_r.shift[6:0], sdi};
            if (lsb) begin
              wbyte = rev8(wbyte);
            end
            wr_en = ~s_r.rd;
            naddr = lsb ? 8'(s_r.addr + 8'h01) : 8'(s_r.addr - 8'h01);
            s_nxt.addr = naddr;
            s_nxt.bit_cnt = 4'h0;
            s_nxt.byte_cnt = 2'(s_r.byte_cnt + 2'h1);
            if (s_r.len != 2'h3 && s_r.byte_cnt == s_r.len) begin
              s_nxt.sp = SP_IDLE;
            end
            s_nxt.obyte = rd_reg(s_r, naddr, rd_ch);
            if (lsb) begin
              s_nxt.obyte = rev8(s_nxt.obyte);
            end
            s_nxt.sdo = s_nxt.obyte[7];
          end
        end else if (!csn && sclk_fall && s_r.rd && s_r.bit_cnt[2:0] != 3'h0) begin
          s_nxt.obyte = {s_r.obyte[6:0], 1'b0};
          s_nxt.sdo = s_r.obyte[6];
        end
      end
      default: s_nxt.sp = SP_IDLE;
    endcase

    if (wr_en) begin
      unique case (s_r.addr)
        `RSN_A_CFG: s_nxt.cfg = wbyte;
        `RSN_A_CHSEL: s_nxt.chsel = wbyte[3:0];
        `RSN_A_TPAT: s_nxt.tpat_sh = wbyte;
        `RSN_A_OFMT: s_nxt.ofmt_sh = wbyte;
        `RSN_A_XFER: s_nxt.xfer = wbyte[0];
        default: ;
      endcase
      for (int c = 0; c < 4; c++) begin
        if (s_r.chsel[c]) begin
          if (s_r.addr == `RSN_A_STCTL) s_nxt.st_sh[c] = wbyte;
          if (s_r.addr == `RSN_A_NSRC) s_nxt.nsrc_sh[c] = wbyte;
          if (s_r.addr == `RSN_A_NSRT) s_nxt.nsrt_sh[c] = wbyte;
        end
      end
    end

    for (int c = 0; c < 4; c++) begin
      st_mask[c] = s_r.st_sh[c][`RSN_ST_EN];
    end
    if (s_r.xfer) begin
      s_nxt.tpat = s_r.tpat_sh;
      s_nxt.ofmt = s_r.ofmt_sh;
      s_nxt.st = s_r.st_sh;
      s_nxt.nsrc = s_r.nsrc_sh;
      s_nxt.nsrt = s_r.nsrt_sh;
      if (|st_mask && !s_r.busy) begin
        s_nxt.busy = 1'b1;
        s_nxt.st_cnt = 9'h000;
        s_nxt.misr = 16'h0000;
        if (!s_r.st_sh[first_ch(st_mask)][`RSN_ST_RESUME]) begin
          s_nxt.st_pn = `RSN_ST_SEED;
        end
      end
    end

    s_nxt.tog = ~s_r.tog;
    s_nxt.pn_long = s_r.tpat[`RSN_TP_RST_LONG] ? `RSN_PN_LONG_SEED :
                    {s_r.pn_long[21:0], s_r.pn_long[22] ^ s_r.pn_long[17]};
    s_nxt.pn_short = s_r.tpat[`RSN_TP_RST_SHORT] ? `RSN_PN_SHORT_SEED :
                     {s_r.pn_short[7:0], s_r.pn_short[8] ^ s_r.pn_short[4]};

    unique case (s_r.tpat[3:0])
      4'h1: pat = `RSN_MIDSCALE;
      4'h2: pat = 11'h7ff;
      4'h3: pat = 11'h000;
      4'h4: pat = s_r.tog ? 11'h555 : 11'h2aa;
      4'h5: pat = s_r.pn_long[10:0];
      4'h6: pat = {s_r.pn_short, s_r.pn_short[8:7]};
      4'h7: pat = s_r.tog ? 11'h7ff : 11'h000;
      default: pat = 11'h000;
    endcase
    // PN patterns bypass formatting so the receiver can check the raw sequence
    pat_raw = (s_r.tpat[3:0] == 4'h5) || (s_r.tpat[3:0] == 4'h6);

    for (int c = 0; c < 4; c++) begin
      st_mask[c] = s_r.st[c][`RSN_ST_EN];
    end
    sign_ch = first_ch(st_mask);
    for (int c = 0; c < 4; c++) begin
      if (s_r.tpat[3:0] != 4'h0) begin
        smp = pat;
      end else if (s_r.busy && st_mask[c]) begin
        smp = s_r.st_pn[10:0];
      end else begin
        smp = adc_data[c];
      end
      if (s_r.ofmt[0] && !(pat_raw && s_r.tpat[3:0] != 4'h0)) begin
        smp[10] = ~smp[10];
      end
      s_nxt.dout[c] = smp;
      if (s_r.busy && 2'(c) == sign_ch) begin
        s_nxt.misr = {s_r.misr[14:0], s_r.misr[15] ^ s_r.misr[13]} ^ {5'h00, smp};
      end
    end

    if (s_r.busy) begin
      s_nxt.st_pn = {s_r.st_pn[14:0],
                     s_r.st_pn[15] ^ s_r.st_pn[13] ^ s_r.st_pn[12] ^ s_r.st_pn[10]};
      s_nxt.st_cnt = 9'(s_r.st_cnt + 9'h001);
      if (s_r.st_cnt == 9'(`RSN_ST_CYCLES - 1)) begin
        s_nxt.busy = 1'b0;
        s_nxt.sig = s_nxt.misr;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_r <= '0;
      s_r.sclk_s <= 3'h0;
      s_r.csn_s <= 3'h7;
      s_r.pin_s <= 2'h3;
      s_r.sp <= SP_IDLE;
      s_r.chsel <= `RSN_CHSEL_RST;
      s_r.st_pn <= `RSN_ST_SEED;
      s_r.pn_long <= `RSN_PN_LONG_SEED;
      s_r.pn_short <= `RSN_PN_SHORT_SEED;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sdio_out = s_r.sdo;
  assign sdio_oe = (s_r.sp == SP_DATA) && s_r.rd && !s_r.csn_s[1];
  assign data_out = s_r.dout;
  assign self_test_busy = s_r.busy;

  always_comb begin
    for (int c = 0; c < 4; c++) begin
      // The pin's pull-up sits in the pad; a floating pin reads high here too
      requant_on[c] = s_r.nsrc[c][`RSN_NSR_IGN] ? s_r.nsrc[c][`RSN_NSR_EN] :
                      ~s_r.pin_s[1];
      band_mode[c] = s_r.nsrc[c][3:1];
      band_left_step[c] = (s_r.nsrt[c][5:0] > tw_max(s_r.nsrc[c][3:1])) ?
                          tw_max(s_r.nsrc[c][3:1]) : s_r.nsrt[c][5:0];
      band_width_step[c] = bw_step(s_r.nsrc[c][3:1]);
    end
  end

  sequence s_frame_open;
    s_r.sp == SP_IDLE && !s_r.csn_s[1] && s_r.sclk_s[1] && !s_r.sclk_s[2];
  endsequence
  sequence s_instr_run;
    s_r.sp == SP_INSTR ##1 s_r.sp != SP_IDLE;
  endsequence

  property p_frame_start;
    @(posedge clk) disable iff (reset) s_frame_open |=> s_r.sp == SP_INSTR;
  endproperty
  a_frame_start: assert property (p_frame_start) else $error("frame not opened");

  property p_pause;
    @(posedge clk) disable iff (reset)
      (s_r.sp == SP_DATA && s_r.len != 2'h3 && s_r.bit_cnt[2:0] == 3'h0 && s_r.csn_s[1])
      |=> s_r.sp == SP_DATA;
  endproperty
  a_pause: assert property (p_pause) else $error("paused frame lost");

  property p_hiz;
    @(posedge clk) disable iff (reset) s_r.csn_s[1] |-> !sdio_oe;
  endproperty
  a_hiz: assert property (p_hiz) else $error("data pin driven while deselected");

  property p_st_len;
    @(posedge clk) disable iff (reset)
      (s_r.busy && s_r.st_cnt == 9'h1ff) |=> !s_r.busy ##1 s_r.st_cnt == 9'h000;
  endproperty
  a_st_len: assert property (p_st_len) else $error("self test length wrong");

  property p_sig;
    @(posedge clk) disable iff (reset) $fell(s_r.busy) |-> s_r.sig == s_r.misr;
  endproperty
  a_sig: assert property (p_sig) else $error("signature not stored");

  property p_pin;
    @(posedge clk) disable iff (reset)
      (!s_r.nsrc[0][`RSN_NSR_IGN] && s_r.pin_s[1]) |-> !requant_on[0];
  endproperty
  a_pin: assert property (p_pin) else $error("requantizer on with pin high");

  property p_ign;
    @(posedge clk) disable iff (reset)
      s_r.nsrc[1][`RSN_NSR_IGN] |-> requant_on[1] == s_r.nsrc[1][`RSN_NSR_EN];
  endproperty
  a_ign: assert property (p_ign) else $error("pin not ignored");

  property p_tw;
    @(posedge clk) disable iff (reset)
      band_left_step[2] <= tw_max(band_mode[2]) && (band_mode[2] != `RSN_MODE36 ||
      band_width_step[2] == `RSN_BW_STEP36);
  endproperty
  a_tw: assert property (p_tw) else $error("tuning word out of range");

  property p_xfer;
    @(posedge clk) disable iff (reset)
      s_r.xfer |=> !s_r.xfer && s_r.tpat == $past(s_r.tpat_sh);
  endproperty
  a_xfer: assert property (p_xfer) else $error("transfer did not apply");

  property p_instr;
    @(posedge clk) disable iff (reset) s_frame_open |=> s_instr_run or s_r.csn_s[1];
  endproperty
  a_instr: assert property (p_instr) else $error("instruction phase dropped");
endmodule

// file: rsn_ctrl_test.sv
`timescale 1ns/100ps
module rsn_ctrl_test;
  logic clk, reset, pin, sclk, sel_n, h_d, h_oe, sdio_out, sdio_oe, busy;
  logic tgl = 1'b0;
  logic [3:0][10:0] adc, dout;
  logic [3:0] rq_on;
  logic [3:0][2:0] mode;
  logic [3:0][5:0] left;
  logic [3:0][6:0] width;
  logic [15:0] sq[$];
  logic [15:0] eq[$];
  logic [6:0] bw_t[0:2] = '{7'h2c, 7'h42, 7'h48};
  logic [5:0] mx_t[0:2] = '{6'h38, 6'h21, 6'h1b};
  logic [10:0] pat_t[0:2] = '{11'h400, 11'h7ff, 11'h000};
  int bcnt = 0;
  int ndif = 0;
  int n_mismatch = 0;
  int checks = 0;
  event res_ev;
  // A released line shows a toggling level, never the last driven bit
  wire logic sdio_w = sdio_oe ? sdio_out : (h_oe ? h_d : tgl);

  rsn_ctrl dut_u (.clk(clk), .reset(reset), .serial_shift_clock(sclk), .select_n(sel_n),
    .sdio_in(sdio_w), .sdio_out(sdio_out), .sdio_oe(sdio_oe), .requant_disable_pin(pin),
    .adc_data(adc), .data_out(dout), .requant_on(rq_on), .band_mode(mode),
    .band_left_step(left), .band_width_step(width), .self_test_busy(busy));
  rsn_host host_u (.clk(clk), .sdio_wire(sdio_w), .sclk(sclk), .select_n(sel_n),
    .sdio_drv(h_d), .sdio_drv_oe(h_oe));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    tgl <= ~tgl;
    if (busy === 1'b1) begin
      bcnt <= bcnt + 1;
      if (dout[1] !== adc[1]) ndif <= ndif + 1;
    end
  end

  task automatic end_of_test();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cmp(input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic obs(input logic [15:0] v, input logic [15:0] e);
    eq.push_back(e);
    sq.push_back(v);
    ->res_ev;
  endtask

  initial forever begin
    @res_ev;
    while (sq.size() > 0) cmp(sq.pop_front(), eq.pop_front());
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    host_u.frame(1'b0, 2'b00, a, {24'h000000, d}, 1'b0, r);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic [31:0] r;
    host_u.frame(1'b1, 2'b00, a, 32'h00000000, 1'b0, r);
    d = r[7:0];
  endtask

  task automatic xfer();
    wr(8'hff, 8'h01);
    repeat (4) @(posedge clk);
  endtask

  task automatic run_st(input logic [7:0] ch, input logic [7:0] ctl, output logic [15:0] sig);
    int b0;
    int d0;
    logic [31:0] r;
    wr(8'h05, 8'h0f);
    wr(8'h0e, 8'h00);
    wr(8'h05, ch);
    wr(8'h0e, ctl);
    // The counters belong to their own process; take a difference instead of clearing them
    b0 = bcnt;
    d0 = ndif;
    wr(8'hff, 8'h01);
    for (int i = 0; i < 700 && busy !== 1'b0; i++) @(posedge clk);
    obs(16'(bcnt - b0), 16'h0200);
    obs({15'h0, ndif > d0}, 16'h0001);
    // Two-byte read with a pause between the bytes
    host_u.frame(1'b1, 2'b01, 8'h25, 32'h00000000, 1'b1, r);
    sig = r[15:0];
  endtask

  initial begin
    repeat (80000) @(posedge clk);
    n_mismatch++;
    end_of_test();
  end

  initial begin
    logic [15:0] s1, s2, s3, d1;
    logic [31:0] r32;
    logic [7:0] r, tw;
    reset = 1'b1;
    pin = 1'b1;
    adc = '0;
    s1 = 16'($urandom(94));
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 4; i++) adc[i] <= 11'($urandom);
    repeat (4) @(posedge clk);
    obs({15'h0, sdio_oe}, 16'h0000);
    obs({12'h0, rq_on}, 16'h0000);
    obs({9'h0, width[0]}, 16'h002c);
    obs({5'h0, dout[1]}, {5'h0, adc[1]});
    for (int m = 0; m < 3; m++) begin
      tw = 8'($urandom_range(63));
      wr(8'h3c, {4'h0, 3'(m), 1'b1});
      wr(8'h3e, tw);
      obs({9'h0, width[2]}, {9'h0, bw_t[m > 0 ? m - 1 : 0]});
      xfer();
      obs({13'h0, mode[2]}, 16'(m));
      obs({9'h0, width[2]}, {9'h0, bw_t[m]});
      obs({10'h0, left[2]}, {10'h0, (tw[5:0] > mx_t[m]) ? mx_t[m] : tw[5:0]});
      rd(8'h3e, r);
      obs({8'h0, r}, {8'h0, tw});
    end
    obs({12'h0, rq_on}, 16'h0000);
    pin <= 1'b0;
    repeat (4) @(posedge clk);
    obs({12'h0, rq_on}, 16'h000f);
    wr(8'h3c, 8'h10);
    xfer();
    obs({12'h0, rq_on}, 16'h0000);
    wr(8'h3c, 8'h11);
    pin <= 1'b1;
    xfer();
    obs({12'h0, rq_on}, 16'h000f);
    rd(8'hff, r);
    obs({8'h0, r}, 16'h0000);
    run_st(8'h02, 8'h01, s1);
    run_st(8'h06, 8'h01, s2);
    obs(s2, s1);
    run_st(8'h02, 8'h05, s3);
    obs({15'h0, s3 !== s1}, 16'h0001);
    // Streamed read: select held low over four bytes, addresses counting down
    host_u.frame(1'b1, 2'b11, 8'h27, 32'h00000000, 1'b0, r32);
    obs(r32[15:0], s3);
    obs(r32[31:16], 16'h0000);
    wr(8'h05, 8'h0f);
    wr(8'h0e, 8'h00);
    for (int p = 1; p < 4; p++) begin
      wr(8'h0d, 8'(p));
      xfer();
      obs({5'h0, dout[3]}, {5'h0, pat_t[p - 1]});
    end
    // Fixed patterns pass through the output formatting: twos complement flips the MSB
    wr(8'h14, 8'h01);
    xfer();
    obs({5'h0, dout[3]}, 16'h0400);
    // Long generator held at its seed must not move
    wr(8'h0d, 8'h15);
    xfer();
    d1 = {5'h0, dout[0]};
    repeat (3) @(posedge clk);
    obs({5'h0, dout[0]}, d1);
    wr(8'h00, 8'h40);
    host_u.lsb = 1'b1;
    rd(8'h3e, r);
    obs({8'h0, r}, {8'h0, tw});
    obs({15'h0, sdio_oe}, 16'h0000);
    repeat (4) @(posedge clk);
    end_of_test();
  end
endmodule

// file: rsn_host.sv
`timescale 1ns/100ps
module rsn_host (
  input wire logic clk,
  input wire logic sdio_wire,
  output logic sclk,
  output logic select_n,
  output logic sdio_drv,
  output logic sdio_drv_oe
);
  logic lsb = 1'b0;

  initial begin
    sclk = 1'b0;
    select_n = 1'b1;
    sdio_drv = 1'b0;
    sdio_drv_oe = 1'b0;
  end

  // Six clk per half period gives the 48 ns shift clock; it idles low outside frames
  task automatic bit_cyc(input logic d, input logic last, output logic q);
    sdio_drv <= d;
    sclk <= 1'b0;
    repeat (6) @(posedge clk);
    sclk <= 1'b1;
    q = sdio_wire;
    // The device takes the bit about two clk after the rise and drives about three after
    repeat (2) @(posedge clk);
    if (last) sdio_drv_oe <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task automatic frame(input logic rd, input logic [1:0] len, input logic [7:0] addr,
      input logic [31:0] wd, input logic pause, output logic [31:0] rdat);
    logic [15:0] ins;
    logic q;
    ins = {rd, len, 5'h00, addr};
    rdat = 32'h00000000;
    @(posedge clk);
    sdio_drv_oe <= 1'b1;
    select_n <= 1'b0;
    repeat (6) @(posedge clk);
    for (int i = 15; i >= 0; i--) begin
      bit_cyc(ins[lsb ? 15 - i : i], rd && i == 0, q);
    end
    for (int b = int'(len); b >= 0; b--) begin
      if (pause && b != int'(len)) begin
        sclk <= 1'b0;
        repeat (6) @(posedge clk);
        select_n <= 1'b1;
        repeat (20) @(posedge clk);
        select_n <= 1'b0;
        repeat (6) @(posedge clk);
      end
      for (int i = 7; i >= 0; i--) begin
        bit_cyc(wd[8 * b + (lsb ? 7 - i : i)], 1'b0, q);
        rdat[8 * b + (lsb ? 7 - i : i)] = q;
      end
    end
    sclk <= 1'b0;
    repeat (6) @(posedge clk);
    select_n <= 1'b1;
    sdio_drv_oe <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
endmodule

// file: rsn_params.svh
`ifndef RSN_PARAMS_SVH
`define RSN_PARAMS_SVH
`define RSN_A_CFG 8'h00
`define RSN_A_CHSEL 8'h05
`define RSN_A_TPAT 8'h0d
`define RSN_A_STCTL 8'h0e
`define RSN_A_OFMT 8'h14
`define RSN_A_SIG0 8'h24
`define RSN_A_SIG1 8'h25
`define RSN_A_NSRC 8'h3c
`define RSN_A_NSRT 8'h3e
`define RSN_A_XFER 8'hff
`define RSN_CFG_LSB 6
`define RSN_NSR_EN 0
`define RSN_NSR_IGN 4
`define RSN_ST_EN 0
`define RSN_ST_RESUME 2
`define RSN_TP_RST_LONG 4
`define RSN_TP_RST_SHORT 5
`define RSN_CHSEL_RST 4'hf
`define RSN_MODE22 3'h0
`define RSN_MODE33 3'h1
`define RSN_MODE36 3'h2
`define RSN_TW_CNT22 6'h39
`define RSN_TW_CNT33 6'h22
`define RSN_TW_CNT36 6'h1c
`define RSN_BW_STEP22 7'h2c
`define RSN_BW_STEP33 7'h42
`define RSN_BW_STEP36 7'h48
`define RSN_ST_CYCLES 512
`define RSN_ST_SEED 16'hace1
`define RSN_PN_LONG_SEED 23'h3afb7d
`define RSN_PN_SHORT_SEED 9'h0df
`define RSN_MIDSCALE 11'h400
`endif

// file: rsn_pkg.sv
package rsn_pkg;
  typedef enum logic [1:0] {SP_IDLE, SP_INSTR, SP_DATA} rsn_sp_t;
  typedef struct packed {
    logic [2:0] sclk_s;
    logic [2:0] csn_s;
    logic [1:0] sdi_s;
    logic [1:0] pin_s;
    rsn_sp_t sp;
    logic [3:0] bit_cnt;
    logic [15:0] shift;
    logic rd;
    logic [1:0] len;
    logic [7:0] addr;
    logic [1:0] byte_cnt;
    logic [7:0] obyte;
    logic sdo;
    logic [7:0] cfg;
    logic [3:0] chsel;
    logic [7:0] tpat_sh;
    logic [7:0] tpat;
    logic [7:0] ofmt_sh;
    logic [7:0] ofmt;
    logic [3:0][7:0] st_sh;
    logic [3:0][7:0] st;
    logic [3:0][7:0] nsrc_sh;
    logic [3:0][7:0] nsrc;
    logic [3:0][7:0] nsrt_sh;
    logic [3:0][7:0] nsrt;
    logic [15:0] sig;
    logic xfer;
    logic busy;
    logic [8:0] st_cnt;
    logic [15:0] st_pn;
    logic [15:0] misr;
    logic [22:0] pn_long;
    logic [8:0] pn_short;
    logic tog;
    logic [3:0][10:0] dout;
  } rsn_state_t;
endpackage
